// >>> common/fbcc_pkg.sv
package fbcc_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam int          FBCC_ADDR_W      = 20;
    localparam logic [19:0] FBCC_CTRL_OFFSET = 20'h43208;
    localparam logic [31:0] FBCC_CTRL_RESET  = 32'h00000000;
    localparam logic [31:0] FBCC_WR_MASK     = 32'hae0000c0;
    localparam logic [31:0] FBCC_EN_MASK     = 32'h80000000;

    // ------------------------------------------------------------
    // field encodings
    // ------------------------------------------------------------
    localparam logic [1:0] FBCC_LIMIT_1TO1 = 2'h0;
    localparam logic [1:0] FBCC_LIMIT_2TO1 = 2'h1;
    localparam logic [1:0] FBCC_LIMIT_4TO1 = 2'h2;
    localparam logic [1:0] FBCC_SHIFT_NONE = 2'h0;
    localparam logic [1:0] FBCC_SHIFT_HALF = 2'h1;
    localparam logic [1:0] FBCC_SHIFT_QTR  = 2'h2;

    typedef struct packed {
        logic        en;
        logic        plane_rsv;
        logic        fence_en;
        logic        rsv28;
        logic        cs_flip_reset_block;
        logic        regpath_flip_reset_block;
        logic        persist;
        logic [16:0] rsv24_8;
        logic [1:0]  limit;
        logic [5:0]  rsv5_0;
    } fbcc_ctrl_t;

    typedef struct packed {
        logic vblank_start;
        logic cs_flip;
        logic reg_flip;
        logic cs_invalidate;
    } fbcc_evt_t;

    typedef enum logic [2:0] {
        FBCC_IDLE = 3'b001,
        FBCC_WAIT = 3'b010,
        FBCC_RUN  = 3'b100
    } fbcc_state_t;

endpackage

// >>> design/fbcc_top.sv
`timescale 1ns/100ps
// Functional notes
// - enable starts compression only at next vblank start; clearing enable stops it
// - fence bit 0 blocks processor writes to display buffer while compression runs; 1 means in fence
// - bit 27 set stops command-streamer sync flips resetting compression
// - bit 26 set stops register-path sync flips resetting compression
// - bit 25 selects persistent mode qualifying command-streamer invalidations
// - bits 7:6 pick limit and packed buffer size: 1:1, 2:1, 4:1, reserved (full size); at 16 bpp 2:1 gives full size, 4:1 half
module fbcc_top
    import fbcc_pkg::*;
#(
    parameter int SIZE_W = 28
) (
    input  wire logic                   mclk,
    input  wire logic                   reset,
    input  wire logic                   mmio_wr,
    input  wire logic                   mmio_rd,
    input  wire logic [FBCC_ADDR_W-1:0] mmio_addr,
    input  wire logic [31:0]            mmio_wdata,
    output logic      [31:0]            mmio_rdata,
    output logic                        mmio_rvalid,
    input  wire fbcc_evt_t              evt,
    input  wire logic                   pix_16bpp,
    input  wire logic [SIZE_W-1:0]      raw_buffer_size,
    output logic                        squeeze_active,
    output logic                        cpu_write_block,
    output logic                        persistent_mode,
    output logic                        invalidate_pass,
    output logic                        discard,
    output logic      [SIZE_W-1:0]      packed_buffer_size
);

    // ------------------------------------------------------------
    // control register
    // ------------------------------------------------------------
    fbcc_ctrl_t        ctrl_q, ctrl_d;
    logic [31:0]       rdata_q, rdata_d;
    logic              rvalid_q, rvalid_d;
    logic              hit;
    logic [31:0]       ctrl_rest;

    assign hit       = (mmio_addr == FBCC_CTRL_OFFSET);
    assign ctrl_rest = ctrl_q & ~FBCC_EN_MASK;

    always_comb begin
        ctrl_d   = ctrl_q;
        rdata_d  = 32'h00000000;
        rvalid_d = mmio_rd;
        if (mmio_wr && hit) begin
            if (ctrl_q.en) begin
                // locked while running, only the enable bit moves
                ctrl_d = (ctrl_q & ~FBCC_EN_MASK) | (mmio_wdata & FBCC_EN_MASK);
            end else begin
                // reserved bits are not stored and read as zero
                ctrl_d = mmio_wdata & FBCC_WR_MASK;
            end
        end
        if (mmio_rd && hit) begin
            rdata_d = ctrl_q;
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            ctrl_q   <= FBCC_CTRL_RESET;
            rdata_q  <= 32'h00000000;
            rvalid_q <= 1'b0;
        end else begin
            ctrl_q   <= ctrl_d;
            rdata_q  <= rdata_d;
            rvalid_q <= rvalid_d;
        end
    end

    assign mmio_rdata      = rdata_q;
    assign mmio_rvalid     = rvalid_q;
    assign persistent_mode = ctrl_q.persist;

    // ------------------------------------------------------------
    // compression state
    // ------------------------------------------------------------
    fbcc_state_t state_q, state_d;

    always_comb begin
        state_d = state_q;
        if (!ctrl_q.en) begin
            state_d = FBCC_IDLE;
        end else begin
            case (state_q)
                FBCC_IDLE: begin
                    state_d = evt.vblank_start ? FBCC_RUN : FBCC_WAIT;
                end
                FBCC_WAIT: begin
                    if (evt.vblank_start) begin
                        state_d = FBCC_RUN;
                    end
                end
                FBCC_RUN: begin
                    state_d = FBCC_RUN;
                end
                default: begin
                    state_d = FBCC_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            state_q <= FBCC_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    assign squeeze_active = state_q[2];

    // ------------------------------------------------------------
    // plane fetch side
    // ------------------------------------------------------------
    logic              block_q, block_d;
    logic              inv_q, inv_d;
    logic              discard_q, discard_d;
    logic [SIZE_W-1:0] size_q, size_d;
    logic [1:0]        shift;

    always_comb begin
        block_d   = squeeze_active && !ctrl_q.fence_en;
        inv_d     = squeeze_active && ctrl_q.persist && evt.cs_invalidate;
        // a flip mid-frame leaves stale packed data, so it is dropped
        discard_d = squeeze_active &&
                    ((evt.cs_flip && !ctrl_q.cs_flip_reset_block) ||
                     (evt.reg_flip && !ctrl_q.regpath_flip_reset_block));
        case (ctrl_q.limit)
            FBCC_LIMIT_1TO1: shift = FBCC_SHIFT_NONE;
            FBCC_LIMIT_2TO1: shift = pix_16bpp ? FBCC_SHIFT_NONE : FBCC_SHIFT_HALF;
            FBCC_LIMIT_4TO1: shift = pix_16bpp ? FBCC_SHIFT_HALF : FBCC_SHIFT_QTR;
            // reserved code falls back to full size, the safe choice
            default:         shift = FBCC_SHIFT_NONE;
        endcase
        size_d = raw_buffer_size >> shift;
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            block_q   <= 1'b0;
            inv_q     <= 1'b0;
            discard_q <= 1'b0;
            size_q    <= '0;
        end else begin
            block_q   <= block_d;
            inv_q     <= inv_d;
            discard_q <= discard_d;
            size_q    <= size_d;
        end
    end

    assign cpu_write_block    = block_q;
    assign invalidate_pass    = inv_q;
    assign discard            = discard_q;
    assign packed_buffer_size = size_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    a_start_on_vblank: assert property ($rose(squeeze_active) |-> $past(evt.vblank_start))
        else $error("compression started without vblank start");
    a_stop_on_clear: assert property (!ctrl_q.en |=> !squeeze_active)
        else $error("compression still active after enable cleared");
    a_wait_then_run: assert property (ctrl_q.en && !squeeze_active && evt.vblank_start ##1 ctrl_q.en
                                      |-> squeeze_active)
        else $error("vblank start did not begin compression");
    a_lock_fields: assert property (ctrl_q.en && mmio_wr && hit |=> $stable(ctrl_rest))
        else $error("locked field changed while enabled");
    a_reserved_zero: assert property (!ctrl_q.plane_rsv && !ctrl_q.rsv28 && ctrl_q.rsv24_8 == 17'h00000
                                      && ctrl_q.rsv5_0 == 6'h00)
        else $error("reserved control bit stored");
    a_fence_block: assert property (squeeze_active && !ctrl_q.fence_en |=> cpu_write_block)
        else $error("processor writes not blocked outside fence");
    a_fence_open: assert property (ctrl_q.fence_en |=> !cpu_write_block)
        else $error("processor writes blocked inside fence");
    a_cs_flip_reset: assert property (squeeze_active && evt.cs_flip && !ctrl_q.cs_flip_reset_block
                                      |=> discard)
        else $error("streamer flip did not reset compression");
    a_cs_flip_hold: assert property (squeeze_active && evt.cs_flip && ctrl_q.cs_flip_reset_block
                                     && !evt.reg_flip |=> !discard)
        else $error("blocked streamer flip reset compression");
    a_reg_flip_reset: assert property (squeeze_active && evt.reg_flip && !ctrl_q.regpath_flip_reset_block
                                       |=> discard)
        else $error("register flip did not reset compression");
    a_reg_flip_hold: assert property (evt.reg_flip && ctrl_q.regpath_flip_reset_block
                                      && !evt.cs_flip |=> !discard)
        else $error("blocked register flip reset compression");
    a_persist_qual: assert property (invalidate_pass |-> $past(ctrl_q.persist) && $past(evt.cs_invalidate))
        else $error("invalidation passed outside persistent mode");
    a_inval_blocked: assert property (!ctrl_q.persist |=> !invalidate_pass)
        else $error("invalidation passed in non-persistent mode");
    a_size_full: assert property (ctrl_q.limit == FBCC_LIMIT_1TO1 ##1 $stable(raw_buffer_size)
                                  |-> packed_buffer_size == raw_buffer_size)
        else $error("equal size setting not full size");
    a_size_half: assert property (ctrl_q.limit == FBCC_LIMIT_2TO1 && !pix_16bpp ##1 $stable(raw_buffer_size)
                                  |-> packed_buffer_size == (raw_buffer_size >> 1))
        else $error("half size wrong at 32 bpp");
    a_size_ratio: assert property (ctrl_q.limit == FBCC_LIMIT_4TO1 && !pix_16bpp ##1 $stable(raw_buffer_size)
                                   |-> packed_buffer_size == (raw_buffer_size >> 2))
        else $error("quarter size wrong at 32 bpp");
    a_size_16bpp: assert property (ctrl_q.limit == FBCC_LIMIT_2TO1 && pix_16bpp ##1 $stable(raw_buffer_size)
                                   |-> packed_buffer_size == raw_buffer_size)
        else $error("half setting at 16 bpp not full size");
    a_qtr_16bpp: assert property (ctrl_q.limit == FBCC_LIMIT_4TO1 && pix_16bpp ##1 $stable(raw_buffer_size)
                                  |-> packed_buffer_size == (raw_buffer_size >> 1))
        else $error("quarter setting at 16 bpp not half size");
    a_discard_cause: assert property (discard |-> $past(squeeze_active))
        else $error("discard while compression idle");

endmodule

// >>> sim/fbcc_far_model.sv
`timescale 1ns/100ps
module fbcc_far_model
    import fbcc_pkg::*;
(
    input  wire logic mclk,
    output fbcc_evt_t evt
);
    initial evt = '0;

    // one-cycle event pulse, launched off the sampling edge
    task automatic pulse(input fbcc_evt_t e);
        @(negedge mclk);
        evt = e;
        @(negedge mclk);
        evt = '0;
    endtask
endmodule

// >>> sim/test_frame_buffer_compression_control.sv
`timescale 1ns/100ps
module test_frame_buffer_compression_control;
    import fbcc_pkg::*;
    logic        mclk = 1'b0, reset = 1'b1, mmio_wr = 1'b0, mmio_rd = 1'b0, pix_16bpp = 1'b0;
    logic        squeeze_active, cpu_write_block, persistent_mode, invalidate_pass, discard, mmio_rvalid;
    logic [19:0] mmio_addr = 20'h0;
    logic [31:0] mmio_wdata = 32'h0, mmio_rdata, cfg;
    logic [27:0] raw_buffer_size = 28'h0, packed_buffer_size;
    fbcc_evt_t   evt;
    int          n_errors = 0, samples_checked = 0, cycles = 0;

    always #25 mclk = ~mclk;

    fbcc_top #(.SIZE_W(28)) dut_u (.mclk(mclk), .reset(reset), .mmio_wr(mmio_wr), .mmio_rd(mmio_rd),
        .mmio_addr(mmio_addr), .mmio_wdata(mmio_wdata), .mmio_rdata(mmio_rdata), .mmio_rvalid(mmio_rvalid),
        .evt(evt), .pix_16bpp(pix_16bpp), .raw_buffer_size(raw_buffer_size), .squeeze_active(squeeze_active),
        .cpu_write_block(cpu_write_block), .persistent_mode(persistent_mode), .invalidate_pass(invalidate_pass),
        .discard(discard), .packed_buffer_size(packed_buffer_size));
    fbcc_far_model far_u (.mclk(mclk), .evt(evt));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wrap_up();
        if (n_errors == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic wr_at(input logic [19:0] a, input logic [31:0] d);
        @(negedge mclk);
        mmio_wr = 1'b1;
        mmio_addr = a;
        mmio_wdata = d;
        @(negedge mclk);
        mmio_wr = 1'b0;
    endtask

    task automatic wr(input logic [31:0] d);
        wr_at(FBCC_CTRL_OFFSET, d);
    endtask

    // read answer lands one edge later and stands one cycle
    task automatic rd(input logic [19:0] a, input logic [31:0] exp);
        @(negedge mclk);
        mmio_rd = 1'b1;
        mmio_addr = a;
        @(negedge mclk);
        mmio_rd = 1'b0;
        chk("rvalid", 32'h1, {31'h0, mmio_rvalid});
        chk("rdata", exp, mmio_rdata);
    endtask

    function automatic logic [27:0] exp_size(input logic [1:0] l, input logic p, input logic [27:0] r);
        if (l == FBCC_LIMIT_2TO1)
            return p ? r : r >> 1;
        if (l == FBCC_LIMIT_4TO1)
            return p ? r >> 1 : r >> 2;
        return r;
    endfunction

    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            wrap_up();
        end
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        void'($urandom(32'h1655));
        repeat (5) @(posedge mclk);
        @(negedge mclk);
        reset = 1'b0;
        rd(FBCC_CTRL_OFFSET, FBCC_CTRL_RESET);
        for (int i = 0; i < 16; i++) begin
            rd(20'h43300 + 20'(i * 4), 32'h0);
            cfg = $urandom & FBCC_WR_MASK & ~FBCC_EN_MASK;
            cfg[7:6] = i[1:0];
            pix_16bpp = 1'($urandom);
            if (i[1:0] == 2'h0 || i[1:0] == 2'h3)
                pix_16bpp = 1'b0;
            raw_buffer_size = 28'($urandom);
            wr(cfg);
            // buffer offset kept 4 KB aligned and only moved while disabled
            wr_at(20'h43200, {4'h0, 16'($urandom), 12'h000});
            // every event while disabled is ignored
            far_u.pulse(fbcc_evt_t'(4'hf));
            chk("idle_active", 32'h0, {31'h0, squeeze_active});
            chk("idle_discard", 32'h0, {31'h0, discard});
            chk("idle_inval", 32'h0, {31'h0, invalidate_pass});
            if (i[2]) begin
                // vblank in the very cycle the enable first reads back set
                fork
                    wr(cfg | FBCC_EN_MASK);
                    begin
                        @(negedge mclk);
                        far_u.pulse(fbcc_evt_t'(4'h8));
                    end
                join
            end else begin
                wr(cfg | FBCC_EN_MASK);
                chk("early_active", 32'h0, {31'h0, squeeze_active});
                far_u.pulse(fbcc_evt_t'(4'h8));
            end
            rd(FBCC_CTRL_OFFSET, cfg | FBCC_EN_MASK);
            chk("persist", {31'h0, cfg[25]}, {31'h0, persistent_mode});
            chk("active", 32'h1, {31'h0, squeeze_active});
            @(negedge mclk);
            chk("cpu_block", {31'h0, ~cfg[29]}, {31'h0, cpu_write_block});
            chk("size", {4'h0, exp_size(cfg[7:6], pix_16bpp, raw_buffer_size)}, {4'h0, packed_buffer_size});
            // fields other than enable stay put while running
            wr(~cfg & FBCC_WR_MASK);
            rd(FBCC_CTRL_OFFSET, cfg | FBCC_EN_MASK);
            for (int k = 0; k < 3; k++) begin
                far_u.pulse(fbcc_evt_t'(4'h4 >> k));
                chk("discard", {31'h0, k == 2 ? 1'b0 : ~cfg[27 - k]}, {31'h0, discard});
                chk("inval", {31'h0, k == 2 && cfg[25]}, {31'h0, invalidate_pass});
            end
            wr(32'h0);
            @(negedge mclk);
            chk("off", 32'h0, {31'h0, squeeze_active});
        end
        wrap_up();
    end
endmodule
